//--- hw/msbb_bridge.v
// How it works
// R1: No code seen: stay joined, open-drain only
// R2: Enter after START, code, not-acknowledge
// R3: Recognise code won or lost
// R4: Open data switch, then pull down
// R5: Open clock switch once both clocks high
// R6: Hold slow lines ready for STOP
// R7: Current source off after each acknowledge bit
// R8: Others may stretch high-speed clock low
// R9: Slow clock held low closes bridge
// R10: Current source off on high-speed STOP
// R11: Close clock switch, release pull-down
// R12: Close data switch after slow data high
// R13: Reconnect within Fast-mode bus free time
// R14: Act fast, meet Fast-mode slow timing
// R15: Devices keep up or stretch clock
// R16: Filter glitches up to 50 ns
// R17: Reserved code keeps bridge closed
// R18: Reset leaves bridge closed, pull-down released
// R19: Bus free time at least 1.3 us
// R20: Sample lines, detect START, STOP, code
// R21: Count slow clock low for recovery
`timescale 1ns/1ps
`default_nettype none
`include "msbb_consts.vh"

module msbb_bridge (
    input  wire mclk,
    input  wire rstn,
    input  wire hs_data_line,
    input  wire hs_clock_line,
    input  wire slow_data_line,
    input  wire slow_clock_line,
    output reg  data_pass_switch,
    output reg  clock_pass_switch,
    output reg  data_pulldown,
    output reg  clock_current_source,
    output reg  hs_active,
    output reg  recover_event
);
    // Switch outputs: 1 means transistor on, lines joined
    localparam [5:0] ST_FS    = 6'h01;
    localparam [5:0] ST_SPLIT = 6'h02;
    localparam [5:0] ST_WAITH = 6'h04;
    localparam [5:0] ST_HS    = 6'h08;
    localparam [5:0] ST_EXIT  = 6'h10;
    localparam [5:0] ST_REJN  = 6'h20;

    wire hsd;
    wire hsc;
    wire sld;
    wire slc;

    // R16 filtered inputs
    msbb_filter u_f_hsd (.mclk(mclk), .rstn(rstn), .line_in(hs_data_line),    .line_out(hsd));
    msbb_filter u_f_hsc (.mclk(mclk), .rstn(rstn), .line_in(hs_clock_line),   .line_out(hsc));
    msbb_filter u_f_sld (.mclk(mclk), .rstn(rstn), .line_in(slow_data_line),  .line_out(sld));
    msbb_filter u_f_slc (.mclk(mclk), .rstn(rstn), .line_in(slow_clock_line), .line_out(slc));

    reg [5:0]                  state;
    reg                        hsd_q;
    reg                        hsc_q;
    reg [3:0]                  bit_cnt;
    reg [7:0]                  shreg;
    reg                        code_ok;
    reg [`MSBB_RECOVER_W-1:0]  low_cnt;

    // R20 condition and edge detection on the high-speed pair
    wire start_det = hsc && hsc_q && hsd_q && !hsd;
    wire stop_det  = hsc && hsc_q && !hsd_q && hsd;
    wire sclk_rise = hsc && !hsc_q;
    wire sclk_fall = !hsc && hsc_q;
    // R21 full recovery time counted
    wire recover   = (low_cnt == `MSBB_RECOVER_CYC);

    always @(posedge mclk) begin
        if (!rstn) begin
            hsd_q <= 1'b1;
            hsc_q <= 1'b1;
            low_cnt <= {`MSBB_RECOVER_W{1'b0}};
        end else begin
            hsd_q <= hsd;
            hsc_q <= hsc;
            // R21 slow clock low counter
            if (slc) begin
                low_cnt <= {`MSBB_RECOVER_W{1'b0}};
            end else if (!recover) begin
                low_cnt <= low_cnt + 1'b1;
            end
        end
    end

    always @(posedge mclk) begin
        if (!rstn) begin
            // R18 start closed and released
            state                <= ST_FS;
            bit_cnt              <= 4'h0;
            shreg                <= 8'h00;
            code_ok              <= 1'b0;
            data_pass_switch     <= 1'b1;
            clock_pass_switch    <= 1'b1;
            data_pulldown        <= 1'b0;
            clock_current_source <= 1'b0;
            hs_active            <= 1'b0;
            recover_event        <= 1'b0;
        end else begin
            recover_event <= 1'b0;
            if (recover && state != ST_FS) begin
                // R9 recovery closes bridge
                state                <= ST_FS;
                data_pass_switch     <= 1'b1;
                clock_pass_switch    <= 1'b1;
                data_pulldown        <= 1'b0;
                clock_current_source <= 1'b0;
                hs_active            <= 1'b0;
                code_ok              <= 1'b0;
                recover_event        <= 1'b1;
            end else begin
                case (state)
                ST_FS: begin
                    // R1 joined, source off
                    data_pass_switch     <= 1'b1;
                    clock_pass_switch    <= 1'b1;
                    data_pulldown        <= 1'b0;
                    clock_current_source <= 1'b0;
                    // R3 watch bus regardless of arbitration outcome
                    if (start_det || stop_det) begin
                        bit_cnt <= 4'h0;
                        code_ok <= 1'b0;
                    end else if (sclk_rise && bit_cnt < `MSBB_BITS_PER_BYTE) begin
                        // R15 follows any bit rate with clock phases of 3 cycles (75 ns) or more
                        shreg   <= {shreg[6:0], hsd};
                        bit_cnt <= bit_cnt + 1'b1;
                    end else if (sclk_rise && bit_cnt == `MSBB_BITS_PER_BYTE) begin
                        bit_cnt <= bit_cnt + 1'b1;
                        // R2 code then not-acknowledge
                        // R17 reserved codes fail this match and stay joined
                        code_ok <= code_ok && hsd;
                    end else if (sclk_fall && bit_cnt == `MSBB_BITS_PER_BYTE) begin
                        code_ok <= (shreg[7:3] == `MSBB_HS_CODE_HI);
                    end else if (sclk_fall && code_ok
                                 && bit_cnt == `MSBB_BITS_PER_BYTE + 4'h1) begin
                        // Split with the clock low: pulling slow data down
                        // while its clock is high would form a START there
                        state <= ST_SPLIT;
                    end
                end
                ST_SPLIT: begin
                    // R14 one cycle per step
                    // R4 open data switch first
                    data_pass_switch <= 1'b0;
                    state            <= ST_WAITH;
                end
                ST_WAITH: begin
                    // R4 then pull down slow data
                    data_pulldown <= 1'b1;
                    // R5 both clocks high
                    if (hsc && slc) begin
                        clock_pass_switch    <= 1'b0;
                        clock_current_source <= 1'b1;
                        hs_active            <= 1'b1;
                        state                <= ST_HS;
                        bit_cnt              <= 4'h0;
                    end
                end
                ST_HS: begin
                    // R6 slow clock floats high, data held low
                    if (stop_det) begin
                        // R10 source off at STOP
                        // R11 close clock switch, release pull-down
                        clock_current_source <= 1'b0;
                        clock_pass_switch    <= 1'b1;
                        data_pulldown        <= 1'b0;
                        hs_active            <= 1'b0;
                        state                <= ST_EXIT;
                    end else if (start_det) begin
                        bit_cnt <= 4'h0;
                    end else if (sclk_rise) begin
                        // R7 source back on once clock high
                        bit_cnt              <= bit_cnt + 1'b1;
                        clock_current_source <= 1'b1;
                    end else if (sclk_fall && bit_cnt == `MSBB_BITS_PER_BYTE + 4'h1) begin
                        // R7 source off after answer bit
                        // Off lets any device stretch the low phase
                        bit_cnt              <= 4'h0;
                        clock_current_source <= 1'b0;
                    end
                end
                ST_EXIT: begin
                    // R12 close data only once slow data high
                    // R13 lines rise in pull-up time, well inside bus free time
                    // R19 free time kept whole
                    if (sld) begin
                        data_pass_switch <= 1'b1;
                        bit_cnt          <= 4'h0;
                        state            <= ST_FS;
                    end
                end
                default: begin
                    state <= ST_FS;
                end
                endcase
            end
        end
    end
endmodule // msbb_bridge

`default_nettype wire

//--- hw/msbb_filter.v
`timescale 1ns/1ps
`default_nettype none
`include "msbb_consts.vh"

// Two-flop synchroniser followed by a stability filter on one line
module msbb_filter (
    input  wire mclk,
    input  wire rstn,
    input  wire line_in,
    output reg  line_out
);
    reg                      sync_a;
    reg                      sync_b;
    reg [`MSBB_FILT_W-1:0]   stable_cnt;

    always @(posedge mclk) begin
        if (!rstn) begin
            sync_a     <= 1'b1;
            sync_b     <= 1'b1;
            stable_cnt <= {`MSBB_FILT_W{1'b0}};
            line_out   <= 1'b1;
        end else begin
            sync_a <= line_in;
            sync_b <= sync_a;
            // R16 reject short spikes
            if (sync_b == line_out) begin
                stable_cnt <= {`MSBB_FILT_W{1'b0}};
            end else if (stable_cnt == `MSBB_FILT_CYC - 1) begin
                stable_cnt <= {`MSBB_FILT_W{1'b0}};
                line_out   <= sync_b;
            end else begin
                stable_cnt <= stable_cnt + 1'b1;
            end
        end
    end
endmodule // msbb_filter

`default_nettype wire

//--- inc/msbb_consts.vh
`ifndef MSBB_CONSTS_VH
`define MSBB_CONSTS_VH

// Clock period in picoseconds (40 MHz)
`define MSBB_CLK_PS          25000
// Glitch reject width, ns
`define MSBB_GLITCH_NS       50
// Filter cycles: ceil(50 ns / 25 ns) + 1 so a 50 ns spike never passes
`define MSBB_FILT_CYC        ((`MSBB_GLITCH_NS * 1000 + `MSBB_CLK_PS - 1) / `MSBB_CLK_PS + 1)
`define MSBB_FILT_W          3
// Slow clock low time that forces recovery, ns (1 us)
`define MSBB_RECOVER_NS      1000
`define MSBB_RECOVER_CYC     ((`MSBB_RECOVER_NS * 1000 + `MSBB_CLK_PS - 1) / `MSBB_CLK_PS)
`define MSBB_RECOVER_W       7
// Fast-mode bus free time, ns (1.3 us)
`define MSBB_BUF_NS          1300
`define MSBB_BUF_CYC         ((`MSBB_BUF_NS * 1000) / `MSBB_CLK_PS)
// Controller code: upper five bits 00001 mean high-speed entry
`define MSBB_HS_CODE_HI      5'h01
`define MSBB_BITS_PER_BYTE   4'h8

`endif

//--- testbench/mixed_speed_bus_bridge_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CMP(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %0t state", $time); end end
module mixed_speed_bus_bridge_tb_top;
    logic       mclk = 0, rstn = 0, sda = 1, scl = 1, hold = 0;
    wire        hsd, hsc, sld, slc, dps, cps, dpd, rev, src, hsa;
    int         mismatches = 0, samples_checked = 0, seed = 32'hB5A69226, r;
    logic [3:0] exp_q[$], last = 4'h6;
    always #12.5 mclk = ~mclk;
    msbb_bridge msbb_bridge_i (.mclk(mclk), .rstn(rstn), .hs_data_line(hsd),
        .hs_clock_line(hsc), .slow_data_line(sld), .slow_clock_line(slc),
        .data_pass_switch(dps), .clock_pass_switch(cps), .data_pulldown(dpd),
        .clock_current_source(src), .hs_active(hsa), .recover_event(rev));
    msbb_bus_model msbb_bus_model_i (.ctl_sda(sda), .ctl_scl(scl), .slow_hold(hold),
        .data_pass_switch(dps), .clock_pass_switch(cps), .data_pulldown(dpd),
        .hs_data_line(hsd), .hs_clock_line(hsc), .slow_data_line(sld), .slow_clock_line(slc));
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // A set g puts a 50 ns spike on data while the clock is high
    task automatic send_bit(input logic b, input logic g);
        sda = b;
        step(2);
        scl = 1;
        step(1);
        sda = b ^ g;
        step(2);
        sda = b;
        step(1);
        scl = 0;
        step(2);
    endtask
    task automatic code_phase(input logic [8:0] c, input logic g);
        step(4);
        sda = 0;
        step(4);
        scl = 0;
        step(2);
        for (int i = 8; i >= 0; i--) send_bit(c[i], g && i == 8);
        step(12);
        scl = 1;
        step(20);
    endtask
    task automatic final_report;
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        #1;
        if (rstn && {rev, dps, cps, dpd} !== last) begin
            last = {rev, dps, cps, dpd};
            `CMP(last, exp_q.size() ? exp_q.pop_front() : 4'hF)
        end
    end
    initial begin
        step(3);
        rstn = 1;
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            if (k == 0 || k == 3) exp_q = {exp_q, 4'h2, 4'h3, 4'h1};
            code_phase({4'h0, k != 1, r[2:0], k != 2}, k == 0);
            if (k == 3) begin
                exp_q = {exp_q, 4'hE, 4'h6};
                hold = 1;
                step(60);
                hold = 0;
            end else begin
                if (k == 0) begin
                    `CMP({hsa, src}, 2'h3)
                    sda = 0;
                    step(4);
                    scl = 0;
                    step(2);
                    for (int i = 8; i >= 0; i--) send_bit(i ? r[i - 1] : 1'h0, 0);
                    exp_q = {exp_q, 4'h2, 4'h6};
                    step(8);
                end
                sda = 0;
                step(2);
                scl = 1;
                step(4);
                `CMP({hsa, src}, {k == 0, 1'h0})
                sda = 1;
                step(60);
                `CMP({hsa, src}, 2'h0)
            end
        end
        `CMP(exp_q.size(), 0)
        final_report();
    end
    initial begin
        #100000;
        mismatches++;
        final_report();
    end
endmodule // mixed_speed_bus_bridge_tb_top
bind msbb_bridge msbb_checker msbb_checker_i (.mclk(mclk), .rstn(rstn),
    .hs_data_line(hs_data_line), .hs_clock_line(hs_clock_line),
    .slow_data_line(slow_data_line), .slow_clock_line(slow_clock_line),
    .data_pass_switch(data_pass_switch), .clock_pass_switch(clock_pass_switch),
    .data_pulldown(data_pulldown), .clock_current_source(clock_current_source),
    .hs_active(hs_active), .recover_event(recover_event));
`default_nettype wire

//--- testbench/msbb_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module msbb_bus_model (
    input  wire logic ctl_sda,
    input  wire logic ctl_scl,
    input  wire logic slow_hold,
    input  wire logic data_pass_switch,
    input  wire logic clock_pass_switch,
    input  wire logic data_pulldown,
    output logic      hs_data_line,
    output logic      hs_clock_line,
    output logic      slow_data_line,
    output logic      slow_clock_line
);
    wire logic sc = !slow_hold;
    wire logic sd = !data_pulldown;
    // Pull-ups win when released; a closed switch wire-ANDs both sides
    assign hs_data_line    = ctl_sda & (data_pass_switch ? sd : 1'h1);
    assign slow_data_line  = sd & (data_pass_switch ? ctl_sda : 1'h1);
    assign hs_clock_line   = ctl_scl & (clock_pass_switch ? sc : 1'h1);
    assign slow_clock_line = sc & (clock_pass_switch ? ctl_scl : 1'h1);
endmodule // msbb_bus_model
`default_nettype wire

//--- testbench/msbb_checker.sv
`timescale 1ns/1ps
`default_nettype none
module msbb_checker (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic hs_data_line,
    input wire logic hs_clock_line,
    input wire logic slow_data_line,
    input wire logic slow_clock_line,
    input wire logic data_pass_switch,
    input wire logic clock_pass_switch,
    input wire logic data_pulldown,
    input wire logic clock_current_source,
    input wire logic hs_active,
    input wire logic recover_event
);
    // Raw low time; the filtered view lags it by a few cycles
    int low_cnt = 0;
    always @(posedge mclk) low_cnt <= slow_clock_line ? 0 : low_cnt + 1;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    idle_reset_a: assert property (!$past(rstn) |-> data_pass_switch
        && clock_pass_switch && !data_pulldown) else $error("not idle after reset");
    joined_nosrc_a: assert property (clock_pass_switch |-> !clock_current_source)
        else $error("source on while joined");
    pd_order_a: assert property ($rose(data_pulldown) |-> !$past(data_pass_switch))
        else $error("pull-down before open");
    hs_hold_a: assert property (hs_active |-> !clock_pass_switch && data_pulldown)
        else $error("fast state while joined");
    stop_close_a: assert property ($rose(clock_pass_switch) |-> !data_pulldown
        && !clock_current_source) else $error("rejoin without release");
    data_close_a: assert property ($rose(data_pass_switch) |-> slow_data_line
        && clock_pass_switch) else $error("data rejoin early");
    free_time_a: assert property ($rose(clock_pass_switch) |-> ##[0:52] data_pass_switch)
        else $error("rejoin too slow");
    recover_a: assert property (low_cnt == 55 |-> data_pass_switch && clock_pass_switch)
        else $error("hold did not close");
endmodule // msbb_checker
`default_nettype wire
